// [core/rsp_consts.svh]
// Constants of the reset source and sleep power controller.
// Assumes a 20 MHz system clock and an Avalon-MM slave with byte addresses.
`ifndef RSP_CONSTS_SVH
`define RSP_CONSTS_SVH

// Clock rate and start-up time-out figures
`define RSP_CLK_MHZ        20
`define RSP_TOUT_MIN_CYC   6
`define RSP_TOUT_SHORT_US  100
`define RSP_TOUT_SHORT_CYC (`RSP_TOUT_SHORT_US * `RSP_CLK_MHZ)
`define RSP_TOUT_LONG_US   4000
`define RSP_CNT_W          17

// Register byte offsets
`define RSP_ADDR_W         4
`define RSP_REG_CAUSE      4'h0
`define RSP_REG_STATUS     4'h4
`define RSP_REG_POWER      4'h8

// Reset-cause register fields
`define RSP_CAUSE_RESET    8'h01
`define RSP_BIT_POWER_ON   0
`define RSP_BIT_EXT        1
`define RSP_BIT_DROOP      2
`define RSP_BIT_WDOG       3
`define RSP_BIT_SCAN       4
`define RSP_BIT_SCAN_DIS   7

// Source synchroniser lanes
`define RSP_SYNC_W         6
`define RSP_LANE_POR       0
`define RSP_LANE_EXT       1
`define RSP_LANE_DROOP     2
`define RSP_LANE_SCAN      3
`define RSP_LANE_SHIFT     4
`define RSP_LANE_TDO       5

`endif

// [core/rsp_pkg.sv]
// Types of the reset source and sleep power controller.
// Assumes nothing beyond the constants header.
package rsp_pkg;

  // Controller states
  typedef enum logic [1:0] {
    RSP_RUN   = 2'h0,
    RSP_HOLD  = 2'h1,
    RSP_WDOG  = 2'h2,
    RSP_COUNT = 2'h3
  } rsp_state_t;

  // Sleep modes as driven by the core
  typedef enum logic [2:0] {
    RSP_SLP_IDLE  = 3'h0,
    RSP_SLP_ADCNR = 3'h1,
    RSP_SLP_PDOWN = 3'h2,
    RSP_SLP_PSAVE = 3'h3,
    RSP_SLP_STBY  = 3'h6,
    RSP_SLP_XSTBY = 3'h7
  } rsp_sleep_mode_t;

  // Fuses, one means programmed
  typedef struct packed {
    logic [3:0] clock_select_fuses;
    logic       brownout_enable_fuse;
    logic       brownout_level_fuse;
    logic       debug_enable_fuse;
    logic       scan_port_enable_fuse;
  } rsp_fuses_t;

  // Analog and clock power controls
  typedef struct packed {
    logic droop_power;
    logic droop_level_high;
    logic wdog_run;
    logic adc_power;
    logic adc_extended_next;
    logic comp_power;
    logic vref_enable;
    logic main_osc_run;
  } rsp_power_t;

endpackage : rsp_pkg

// [core/rsp_reset_ctrl.sv]
// Reset source combiner, start-up delay counter and sleep power gating.
// Assumes watchdog and core inputs on i_clock; pin, detector and scan inputs asynchronous.
//
// What this block does
// - Internal reset reloads I/O registers; release pulses a reset-vector fetch.
// - Any pin or detector reset sets port reset at once, no clock needed.
// - After all sources drop, a fuse-selected delay count stretches internal reset.
// - Exactly five causes: supply rise, pin, watchdog, supply droop, scan port.
// - Pin low long enough resets without clock; short pulses may be missed.
// - Pin release starts the delay count; processor freed after the time-out.
// - Watchdog reset only when watchdog enabled and its time-out expires.
// - Watchdog time-out gives a one-cycle reset pulse; count starts after it.
// - Scan-chain reset bit at one holds the processor in reset.
// - Supply low asserts reset immediately; recovery starts the delay count.
// - Enabled droop detector trip resets at once; recovery waits the time-out.
// - Level fuse picks low or high droop level; enable fuse gates the detector.
// - Fuse-enabled droop detector stays powered in every sleep mode.
// - Enabled watchdog keeps running in every sleep mode.
// - ADC power follows its enable in sleep; off-on makes next conversion extended.
// - Comparator off in sleep except idle and noise reduction; its reference stays.
// - Voltage reference on only while droop detector, comparator or ADC needs it.
// - Input buffers off when I/O and ADC clocks stop, except wake-up pins.
// - Debug fuse with the scan port enabled keeps main oscillator running in power-down and power-save.
// - Disable bit or unprogrammed enable fuse turns the scan port off.
// - Enabled scan port leaves TDO undriven unless the TAP is shifting.
// - Each cause sets its flag; supply rise or zero-write clears; power flag only zero-write.
`timescale 1ns/10ps
`default_nettype none
`include "rsp_consts.svh"

module rsp_reset_ctrl #(
  parameter int unsigned P_TOUT_LONG_CYC = `RSP_TOUT_LONG_US * `RSP_CLK_MHZ
) (
  input  wire logic                       i_clock,
  input  wire logic                       i_rst,
  input  wire logic                       i_clk_en,
  input  wire rsp_pkg::rsp_fuses_t        i_fuses,
  input  wire logic                       i_supply_low,
  input  wire logic                       i_ext_reset_n,
  input  wire logic                       i_droop_trip,
  input  wire logic                       i_wdog_enable,
  input  wire logic                       i_wdog_timeout,
  input  wire logic                       i_scan_reset_bit,
  input  wire logic                       i_tap_shifting,
  input  wire logic                       i_tap_tdo,
  input  wire logic                       i_sleep,
  input  wire rsp_pkg::rsp_sleep_mode_t   i_sleep_mode,
  input  wire logic                       i_adc_enable,
  input  wire logic                       i_adc_conv_start,
  input  wire logic                       i_comp_enable,
  input  wire logic                       i_comp_uses_ref,
  input  wire logic [7:0]                 i_wake_pins,
  input  wire logic [`RSP_ADDR_W-1:0]     i_avs_address,
  input  wire logic                       i_avs_read,
  input  wire logic                       i_avs_write,
  input  wire logic [31:0]                i_avs_writedata,
  input  wire logic [3:0]                 i_avs_byteenable,
  output logic [31:0]                     o_avs_readdata,
  output logic                            o_avs_waitrequest,
  output logic                            o_port_reset,
  output logic                            o_core_reset,
  output logic                            o_vector_fetch,
  output logic                            o_scan_enable,
  output logic                            o_tdo,
  output logic                            o_tdo_oe,
  output logic [7:0]                      o_input_buf_en,
  output rsp_pkg::rsp_power_t             o_power
);

  // Clocked state of the controller, all but the port reset flop
  typedef struct packed {
    logic [`RSP_SYNC_W-1:0] sync0;
    logic [`RSP_SYNC_W-1:0] sync1;
    rsp_pkg::rsp_state_t    state;
    logic [`RSP_CNT_W-1:0]  cnt;
    logic                   core_reset;
    logic                   vector_fetch;
    logic [7:0]             cause;
    logic                   adc_prev;
    logic                   waitreq;
    logic [31:0]            rdata;
    logic                   scan_enable;
    logic                   tdo;
    logic                   tdo_oe;
    logic [7:0]             buf_en;
    rsp_pkg::rsp_power_t    power;
  } rsp_regs_t;

  rsp_regs_t             r;
  rsp_regs_t             next_r;
  logic                  async_src;
  logic                  next_port_reset;
  logic                  any_src;
  logic                  wdog_evt;
  logic                  clocks_stopped;
  logic [`RSP_CNT_W-1:0] limit;
  logic                  bus_take;

  // Asynchronous reset sources that act without a clock
  assign async_src = i_rst | i_supply_low | ~i_ext_reset_n |
                     (i_fuses.brownout_enable_fuse & i_droop_trip);

  // Synchronised sources, four of the five causes, watchdog apart
  assign any_src  = r.sync1[`RSP_LANE_POR] | r.sync1[`RSP_LANE_EXT] |
                    r.sync1[`RSP_LANE_DROOP] | r.sync1[`RSP_LANE_SCAN];
  assign wdog_evt = i_wdog_timeout & i_wdog_enable;

  // Time-out length chosen by the fuses
  always_comb begin
    case (i_fuses.clock_select_fuses[1:0])
      2'h0:    limit = `RSP_CNT_W'(`RSP_TOUT_MIN_CYC);
      2'h1:    limit = `RSP_CNT_W'(`RSP_TOUT_SHORT_CYC);
      default: limit = `RSP_CNT_W'(P_TOUT_LONG_CYC);
    endcase
  end

  // I/O and ADC clocks both stop in every mode but idle and noise reduction
  assign clocks_stopped = i_sleep && (i_sleep_mode != rsp_pkg::RSP_SLP_IDLE) &&
                          (i_sleep_mode != rsp_pkg::RSP_SLP_ADCNR);

  assign bus_take = (i_avs_read | i_avs_write) & ~r.waitreq;

  // Next-state logic
  always_comb begin
    next_r = r;
    // Two-stage synchronisers
    next_r.sync0[`RSP_LANE_POR]   = i_supply_low;
    next_r.sync0[`RSP_LANE_EXT]   = ~i_ext_reset_n;
    next_r.sync0[`RSP_LANE_DROOP] = i_droop_trip & i_fuses.brownout_enable_fuse;
    next_r.sync0[`RSP_LANE_SCAN]  = i_scan_reset_bit & r.scan_enable;
    next_r.sync0[`RSP_LANE_SHIFT] = i_tap_shifting;
    next_r.sync0[`RSP_LANE_TDO]   = i_tap_tdo;
    next_r.sync1 = r.sync0;

    // Reset sequencer
    next_r.vector_fetch = 1'b0;
    if (any_src) begin
      next_r.state = rsp_pkg::RSP_HOLD;
      next_r.cnt   = '0;
    end else begin
      case (r.state)
        rsp_pkg::RSP_HOLD: begin
          next_r.state = rsp_pkg::RSP_COUNT;
          next_r.cnt   = '0;
        end
        rsp_pkg::RSP_WDOG: begin
          next_r.state = rsp_pkg::RSP_COUNT;
          next_r.cnt   = '0;
        end
        rsp_pkg::RSP_COUNT: begin
          if (r.cnt >= limit - `RSP_CNT_W'(1)) begin
            next_r.state        = rsp_pkg::RSP_RUN;
            next_r.vector_fetch = 1'b1;
          end else begin
            next_r.cnt = r.cnt + `RSP_CNT_W'(1);
          end
        end
        rsp_pkg::RSP_RUN: begin
          if (wdog_evt) begin
            next_r.state = rsp_pkg::RSP_WDOG;
          end
        end
        default: begin
          next_r.state = rsp_pkg::RSP_HOLD;
        end
      endcase
    end
    next_r.core_reset = (next_r.state != rsp_pkg::RSP_RUN);

    // Software writes: zero clears a flag, one leaves it
    if (bus_take && i_avs_write && i_avs_byteenable[0] &&
        i_avs_address == `RSP_REG_CAUSE) begin
      next_r.cause[4:0] = r.cause[4:0] & i_avs_writedata[4:0];
      next_r.cause[`RSP_BIT_SCAN_DIS] = i_avs_writedata[`RSP_BIT_SCAN_DIS];
    end
    // Hardware sets win over the clear
    if (r.sync1[`RSP_LANE_POR]) begin
      next_r.cause = `RSP_CAUSE_RESET;
    end else begin
      if (r.sync1[`RSP_LANE_EXT])   next_r.cause[`RSP_BIT_EXT]   = 1'b1;
      if (r.sync1[`RSP_LANE_DROOP]) next_r.cause[`RSP_BIT_DROOP] = 1'b1;
      if (r.sync1[`RSP_LANE_SCAN])  next_r.cause[`RSP_BIT_SCAN]  = 1'b1;
      if (r.state == rsp_pkg::RSP_RUN && wdog_evt) begin
        next_r.cause[`RSP_BIT_WDOG] = 1'b1;
      end
    end

    // Bus slave: one wait cycle, then the answer
    next_r.waitreq = 1'b1;
    if ((i_avs_read | i_avs_write) && r.waitreq) begin
      next_r.waitreq = 1'b0;
      case (i_avs_address)
        `RSP_REG_CAUSE:  next_r.rdata = {24'h00_0000, r.cause};
        `RSP_REG_STATUS: next_r.rdata = {8'h00, r.cnt, r.scan_enable, r.adc_prev,
                                         r.vector_fetch, r.state, r.core_reset,
                                         o_port_reset};
        `RSP_REG_POWER:  next_r.rdata = {16'h0000, r.buf_en, r.power};
        default:         next_r.rdata = 32'h0000_0000;
      endcase
    end

    // Scan port and TDO drive
    next_r.scan_enable = i_fuses.scan_port_enable_fuse &
                         ~next_r.cause[`RSP_BIT_SCAN_DIS];
    next_r.tdo_oe = r.scan_enable & r.sync1[`RSP_LANE_SHIFT];
    next_r.tdo    = r.sync1[`RSP_LANE_TDO];

    // Sleep power gating
    next_r.power.droop_power      = i_fuses.brownout_enable_fuse;
    next_r.power.droop_level_high = i_fuses.brownout_level_fuse;
    next_r.power.wdog_run         = i_wdog_enable;
    next_r.power.adc_power        = i_adc_enable;
    next_r.adc_prev               = i_adc_enable;
    if (i_adc_enable && !r.adc_prev) begin
      next_r.power.adc_extended_next = 1'b1;
    end else if (i_adc_conv_start) begin
      next_r.power.adc_extended_next = 1'b0;
    end
    next_r.power.comp_power  = i_comp_enable & ~clocks_stopped;
    next_r.power.vref_enable = i_fuses.brownout_enable_fuse | i_adc_enable |
                               (i_comp_enable & i_comp_uses_ref);
    next_r.buf_en = clocks_stopped ? i_wake_pins : 8'hFF;
    next_r.power.main_osc_run = !i_sleep ||
      !(i_sleep_mode == rsp_pkg::RSP_SLP_PDOWN || i_sleep_mode == rsp_pkg::RSP_SLP_PSAVE) ||
      (i_fuses.debug_enable_fuse & r.scan_enable);
  end

  // Register the state, frozen while the clock enable is low
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      r              <= '0;
      r.state        <= rsp_pkg::RSP_HOLD;
      r.core_reset   <= 1'b1;
      r.cause        <= `RSP_CAUSE_RESET;
      r.waitreq      <= 1'b1;
      r.buf_en       <= 8'hFF;
      r.power.main_osc_run <= 1'b1;
    end else if (i_clk_en) begin
      r <= next_r;
    end
  end

  // Port reset flop: set at once by the asynchronous sources
  assign next_port_reset = next_r.core_reset;
  always_ff @(posedge i_clock or posedge async_src) begin
    if (async_src) begin
      o_port_reset <= 1'b1;
    end else if (i_clk_en) begin
      o_port_reset <= next_port_reset;
    end
  end

  // Outputs straight from the state
  assign o_avs_readdata    = r.rdata;
  assign o_avs_waitrequest = r.waitreq;
  assign o_core_reset      = r.core_reset;
  assign o_vector_fetch    = r.vector_fetch;
  assign o_scan_enable     = r.scan_enable;
  assign o_tdo             = r.tdo;
  assign o_tdo_oe          = r.tdo_oe;
  assign o_input_buf_en    = r.buf_en;
  assign o_power           = r.power;

  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence s_wdog_hit;
    i_clk_en && r.state == rsp_pkg::RSP_RUN && wdog_evt && !any_src;
  endsequence
  sequence s_wdog_pulse;
    r.state == rsp_pkg::RSP_WDOG && o_core_reset;
  endsequence

  a_wdog_one_pulse: assert property (s_wdog_hit |=> s_wdog_pulse ##1
    (!$past(i_clk_en) || $past(any_src) || r.state == rsp_pkg::RSP_COUNT && r.cnt == '0))
    else $error("watchdog pulse not one cycle");
  a_wdog_gated: assert property (i_clk_en && r.state == rsp_pkg::RSP_RUN && !any_src &&
    !(i_wdog_timeout && i_wdog_enable) |=> r.state == rsp_pkg::RSP_RUN)
    else $error("reset without enabled watchdog time-out");
  a_src_restart: assert property (i_clk_en && any_src |=>
    r.state == rsp_pkg::RSP_HOLD && r.cnt == '0 && o_core_reset)
    else $error("source did not restart counter");
  a_count_release: assert property (i_clk_en && !any_src &&
    r.state == rsp_pkg::RSP_COUNT && r.cnt == limit - `RSP_CNT_W'(1)
    |=> !o_core_reset && o_vector_fetch)
    else $error("release not at fuse count");
  a_count_holds: assert property (i_clk_en && r.state == rsp_pkg::RSP_COUNT &&
    r.cnt < limit - `RSP_CNT_W'(1) |=> o_core_reset)
    else $error("early release");
  a_port_async: assert property (async_src |-> o_port_reset)
    else $error("port reset missing under async source");
  a_tdo_float: assert property (i_clk_en && !(r.scan_enable && r.sync1[`RSP_LANE_SHIFT])
    |=> !o_tdo_oe)
    else $error("TDO driven while idle");
  a_vref_need: assert property (i_clk_en && !i_fuses.brownout_enable_fuse && !i_adc_enable &&
    !i_comp_enable |=> !o_power.vref_enable)
    else $error("reference on without a user");
  a_flag_set_wins: assert property (i_clk_en && r.sync1[`RSP_LANE_EXT] &&
    !r.sync1[`RSP_LANE_POR] |=> r.cause[`RSP_BIT_EXT])
    else $error("external flag lost");
  a_bus_answer: assert property ((i_avs_read || i_avs_write) && r.waitreq && i_clk_en
    |=> !o_avs_waitrequest ##1 (o_avs_waitrequest || !$past(i_clk_en)))
    else $error("bus answer not one cycle");

  // Sequencer steps between the checks above
  a_hold_to_count: assert property (i_clk_en && !any_src &&
    r.state == rsp_pkg::RSP_HOLD |=> r.state == rsp_pkg::RSP_COUNT && o_core_reset)
    else $error("hold did not start count");

  a_count_step: assert property (i_clk_en && !any_src &&
    r.state == rsp_pkg::RSP_COUNT && r.cnt < limit - `RSP_CNT_W'(1)
    |=> r.cnt == $past(r.cnt) + `RSP_CNT_W'(1))
    else $error("count did not advance");

  a_vfetch_pulse: assert property (i_clk_en && o_vector_fetch
    |=> !o_vector_fetch)
    else $error("fetch pulse too long");

  a_freeze_state: assert property (!i_clk_en
    |=> $stable(r.state) && $stable(r.cnt))
    else $error("state moved while frozen");

  // Reset-cause flags
  a_por_cause: assert property (i_clk_en && r.sync1[`RSP_LANE_POR]
    |=> r.cause == `RSP_CAUSE_RESET)
    else $error("supply-rise flags wrong");

  a_wdog_cause: assert property (i_clk_en && r.state == rsp_pkg::RSP_RUN && wdog_evt &&
    !r.sync1[`RSP_LANE_POR] |=> r.cause[`RSP_BIT_WDOG])
    else $error("watchdog flag lost");

  a_scan_cause: assert property (i_clk_en && r.sync1[`RSP_LANE_SCAN] &&
    !r.sync1[`RSP_LANE_POR] |=> r.cause[`RSP_BIT_SCAN])
    else $error("scan flag lost");

  // Fuse gating of the droop detector and scan port
  a_droop_fuse: assert property (i_clk_en && !i_fuses.brownout_enable_fuse
    |=> !r.sync0[`RSP_LANE_DROOP])
    else $error("droop seen while fused off");

  a_scan_off: assert property (i_clk_en && !i_fuses.scan_port_enable_fuse
    |=> !o_scan_enable)
    else $error("scan port on without fuse");

  // Sleep power outputs
  a_droop_power: assert property (i_clk_en && i_fuses.brownout_enable_fuse
    |=> o_power.droop_power)
    else $error("droop detector unpowered");

  a_wdog_run: assert property (i_clk_en && i_wdog_enable
    |=> o_power.wdog_run)
    else $error("watchdog stopped");

  a_adc_ext_set: assert property (i_clk_en && i_adc_enable && !r.adc_prev
    |=> o_power.adc_extended_next)
    else $error("extended conversion missed");

  a_comp_sleep: assert property (i_clk_en && clocks_stopped
    |=> !o_power.comp_power)
    else $error("comparator on in deep sleep");

  a_buf_gate: assert property (i_clk_en && clocks_stopped
    |=> o_input_buf_en == $past(i_wake_pins))
    else $error("input buffers not gated");

  a_buf_open: assert property (i_clk_en && !clocks_stopped
    |=> o_input_buf_en == 8'hFF)
    else $error("input buffers off awake");

  a_osc_hold: assert property (i_clk_en && i_fuses.debug_enable_fuse &&
    r.scan_enable |=> o_power.main_osc_run)
    else $error("oscillator stopped in debug");

endmodule : rsp_reset_ctrl

`default_nettype wire

// [verification/rsp_far_model.sv]
// Far-side model: supply detectors, reset pin, watchdog and scan port.
// Assumes bench requests change just after rising i_clock edges.
`timescale 1ns/10ps
`default_nettype none
module rsp_far_model (
  input  wire logic       i_clock,
  input  wire logic [4:0] i_req,
  input  wire logic       i_wd_en,
  input  wire logic       i_shift,
  output logic            o_supply_low,
  output logic            o_ext_reset_n,
  output logic            o_droop_trip,
  output logic            o_scan_reset_bit,
  output logic            o_wdog_enable,
  output var logic        o_wdog_timeout,
  output logic            o_tap_shifting,
  output logic            o_tap_tdo
);
  logic fire_q = 1'h0;
  logic tdo_q  = 1'h0;
  // Detector and pin levels follow the requests
  assign o_supply_low     = i_req[0];
  assign o_ext_reset_n    = ~i_req[1];
  assign o_droop_trip     = i_req[2];
  assign o_scan_reset_bit = i_req[3];
  assign o_wdog_enable    = i_wd_en;
  assign o_tap_shifting   = i_shift;
  assign o_tap_tdo        = tdo_q;
  // One-cycle time-out on a new request; scan data changes every cycle
  always_ff @(posedge i_clock) begin
    fire_q         <= i_req[4];
    o_wdog_timeout <= i_req[4] & ~fire_q;
    tdo_q          <= ~tdo_q;
  end
endmodule : rsp_far_model
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench of the reset and sleep power controller.
// Assumes the core files and rsp_far_model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "rsp_consts.svh"
module tb_top;
  localparam int LONG = 50;
  logic                    i_clock = 1'h0;
  logic                    i_rst   = 1'h1;
  logic                    clk_en  = 1'h1;
  rsp_pkg::rsp_fuses_t     fuses   = 8'h09;
  logic [4:0]              req     = 5'h00;
  logic                    wd_en   = 1'h0;
  logic                    shift   = 1'h0;
  logic                    sleep   = 1'h0;
  rsp_pkg::rsp_sleep_mode_t mode   = rsp_pkg::RSP_SLP_IDLE;
  logic                    adc_en  = 1'h0;
  logic                    conv    = 1'h0;
  logic                    cmp_en  = 1'h0;
  logic                    cmp_ref = 1'h0;
  logic [3:0]              addr    = 4'h0;
  logic                    rd_s    = 1'h0;
  logic                    wr_s    = 1'h0;
  logic [31:0]             wdat    = 32'h0000_0000;
  logic                    sup, pin_n, drp, scn, wde, wdt, tsh, ttdo;
  logic [31:0]             rdat;
  logic                    wreq, port_rst, core_rst, vfetch, scan_en, tdo, tdo_oe;
  logic [7:0]              bufen;
  rsp_pkg::rsp_power_t     pwr;
  int                      err_total = 0;
  int                      n_compared = 0;
  int                      cyc = 0;
  logic [31:0]             q;

  always #25 i_clock = ~i_clock;

  rsp_far_model u_far (.i_clock(i_clock), .i_req(req), .i_wd_en(wd_en), .i_shift(shift),
    .o_supply_low(sup), .o_ext_reset_n(pin_n), .o_droop_trip(drp), .o_scan_reset_bit(scn),
    .o_wdog_enable(wde), .o_wdog_timeout(wdt), .o_tap_shifting(tsh), .o_tap_tdo(ttdo));

  rsp_reset_ctrl #(.P_TOUT_LONG_CYC(LONG)) u_dut (.i_clock(i_clock), .i_rst(i_rst),
    .i_clk_en(clk_en), .i_fuses(fuses), .i_supply_low(sup), .i_ext_reset_n(pin_n),
    .i_droop_trip(drp), .i_wdog_enable(wde), .i_wdog_timeout(wdt), .i_scan_reset_bit(scn),
    .i_tap_shifting(tsh), .i_tap_tdo(ttdo), .i_sleep(sleep), .i_sleep_mode(mode),
    .i_adc_enable(adc_en), .i_adc_conv_start(conv), .i_comp_enable(cmp_en),
    .i_comp_uses_ref(cmp_ref), .i_wake_pins(8'h05), .i_avs_address(addr),
    .i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_writedata(wdat),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .o_port_reset(port_rst), .o_core_reset(core_rst), .o_vector_fetch(vfetch),
    .o_scan_enable(scan_en), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_input_buf_en(bufen),
    .o_power(pwr));

  task automatic conclude;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  // Hang guard
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Avalon-MM transfer held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] rq);
    logic w;
    @(posedge i_clock);
    addr <= a;
    wdat <= d;
    wr_s <= wr;
    rd_s <= ~wr;
    do begin
      @(posedge i_clock);
      w  = wreq;
      rq = rdat;
    end while (w !== 1'h0);
    wr_s <= 1'h0;
    rd_s <= 1'h0;
  endtask : bus

  task automatic wait_run(output int n);
    n = 0;
    do begin
      @(negedge i_clock);
      n++;
    end while (core_rst !== 1'h0 && n < 3000);
  endtask : wait_run

  // Pin reset, then stretch length for a delay selection
  task automatic s_tout(input logic [3:0] sel, input int lim);
    int n;
    @(posedge i_clock) fuses <= {sel, 4'h9};
    req[1] <= 1'h1;
    @(negedge i_clock) check("port_reset", port_rst, 1'h1);
    repeat (4) @(posedge i_clock);
    req[1] <= 1'h0;
    wait_run(n);
    check("tout_len", n >= lim && n <= lim + 6, 1'h1);
    check("vec_fetch", vfetch, 1'h1);
    @(negedge i_clock) check("vec_fetch_end", vfetch, 1'h0);
  endtask : s_tout

  // One reset cause, its effect and its flag
  task automatic s_source(input int k, input logic on, input logic [7:0] cause);
    logic hit;
    int   n;
    bus(1'h1, `RSP_REG_CAUSE, 32'h0000_0000, q);
    hit = 1'h0;
    @(posedge i_clock) req[k] <= 1'h1;
    @(negedge i_clock) if (k < 3) check("port_async", port_rst, on);
    repeat (7) begin
      @(negedge i_clock);
      hit |= core_rst;
    end
    @(posedge i_clock) req[k] <= 1'h0;
    wait_run(n);
    check("core_reset_seen", hit, on);
    bus(1'h0, `RSP_REG_CAUSE, 32'h0000_0000, q);
    check("cause", q, {24'h00_0000, cause});
  endtask : s_source

  // Sleep gating across all six modes
  task automatic s_sleep(input logic full);
    logic [2:0] mv [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    logic [7:0] pw;
    logic       pd;
    for (int i = 0; i < 6; i++) begin
      @(posedge i_clock) sleep <= 1'h1;
      mode <= rsp_pkg::rsp_sleep_mode_t'(mv[i]);
      repeat (3) @(negedge i_clock);
      pd = mv[i][2:1] == 2'h1;
      pw = {full, full, 1'h1, full, 1'h0, i < 2, 1'h1, full | ~pd};
      check("power", pwr & 8'hF7, pw);
      check("in_buf", bufen, mv[i][1] ? 8'h05 : 8'hFF);
    end
  endtask : s_sleep

  // Scan port enable, TDO drive and both ways of turning the port off
  task automatic s_scan;
    repeat (5) @(negedge i_clock);
    check("scan_en", scan_en, 1'h1);
    check("tdo_idle", tdo_oe, 1'h0);
    @(posedge i_clock) shift <= 1'h1;
    repeat (5) @(negedge i_clock);
    check("tdo_shift", tdo_oe, 1'h1);
    q[0] = tdo;
    @(negedge i_clock) check("tdo_data", tdo ^ q[0], 1'h1);
    bus(1'h1, `RSP_REG_CAUSE, 32'h0000_0080, q);
    shift <= 1'h0;
    repeat (3) @(negedge i_clock);
    check("scan_dis", scan_en, 1'h0);
    bus(1'h1, `RSP_REG_CAUSE, 32'h0000_0000, q);
    fuses <= 8'h00;
    repeat (3) @(negedge i_clock);
    check("scan_fuse", scan_en, 1'h0);
  endtask : s_scan

  // Reference off without users, ADC enable across a frozen spell
  task automatic s_adc;
    @(posedge i_clock) sleep <= 1'h0;
    cmp_en <= 1'h0;
    repeat (3) @(negedge i_clock);
    check("vref_off", pwr.vref_enable, 1'h0);
    @(posedge i_clock) clk_en <= 1'h0;
    adc_en <= 1'h1;
    repeat (3) @(negedge i_clock);
    check("adc_frozen", pwr.adc_power, 1'h0);
    @(posedge i_clock) clk_en <= 1'h1;
    repeat (3) @(negedge i_clock);
    check("adc_ext", pwr.adc_extended_next, 1'h1);
    @(posedge i_clock) conv <= 1'h1;
    @(posedge i_clock) conv <= 1'h0;
    repeat (3) @(negedge i_clock);
    check("adc_ext_clr", pwr.adc_extended_next, 1'h0);
  endtask : s_adc

  initial begin
    repeat (2) @(posedge i_clock);
    i_rst <= 1'h0;
    bus(1'h0, `RSP_REG_CAUSE, 32'h0000_0000, q);
    check("cause_rst", q, 32'h0000_0001);
    s_tout(4'h0, 6);
    s_tout(4'h1, 2000);
    s_tout(4'h2, LONG);
    @(posedge i_clock) fuses <= 8'h09;
    s_source(0, 1'h1, 8'h01);
    s_source(1, 1'h1, 8'h02);
    s_source(2, 1'h1, 8'h04);
    s_source(3, 1'h1, 8'h10);
    wd_en <= 1'h1;
    s_source(4, 1'h1, 8'h08);
    wd_en <= 1'h0;
    s_source(4, 1'h0, 8'h00);
    fuses <= 8'h01;
    s_source(2, 1'h0, 8'h00);
    s_scan();
    // Sleep: everything on, then comparator on the reference only
    @(posedge i_clock) fuses <= 8'h0F;
    wd_en   <= 1'h1;
    adc_en  <= 1'h1;
    cmp_en  <= 1'h1;
    s_sleep(1'h1);
    @(posedge i_clock) fuses <= 8'h01;
    adc_en  <= 1'h0;
    cmp_ref <= 1'h1;
    s_sleep(1'h0);
    s_adc();
    conclude();
  end
endmodule : tb_top
`default_nettype wire
